// [include/fpcs_pkg.sv]
package fpcs_pkg;

    // control register numbers
    localparam logic [4:0]  CTL_IMPL_REV    = 5'h00;
    localparam logic [4:0]  CTL_STATUS      = 5'h1f;

    // implementation/revision word layout
    localparam int          IMPL_LSB        = 8;
    localparam int          REV_LSB         = 0;
    localparam int          ID_WIDTH        = 8;

    // status word layout
    localparam int          COND_LO_BIT     = 23;
    localparam int          COND_HI_LSB     = 25;
    localparam int          FLUSH_BIT       = 24;
    localparam int          CAUSE_LSB       = 12;
    localparam int          ENABLE_LSB      = 7;
    localparam int          FLAG_LSB        = 2;
    localparam int          RM_LSB          = 0;
    localparam int          COND_COUNT      = 8;
    localparam int          CAUSE_WIDTH     = 6;
    localparam int          IEEE_WIDTH      = 5;
    localparam logic [31:0] UNIMPL_MASK     = 32'h007c0000;
    localparam logic [31:0] STATUS_RESET    = 32'h00000000;

    // cause vector positions (vector bits 4:0 line up with enables/flags)
    localparam int          CAUSE_E         = 5;
    localparam int          CAUSE_V         = 4;
    localparam int          CAUSE_Z         = 3;
    localparam logic [5:0]  CAUSE_NONE      = 6'h00;
    localparam logic [5:0]  CAUSE_E_ONLY    = 6'h20;

    typedef enum logic [1:0]
    {
        round_nearest_even    = 2'h0,
        round_toward_zero     = 2'h1,
        round_toward_plus_inf = 2'h2,
        round_toward_minus_inf = 2'h3
    } rounding_t;

    // kind of instruction at graduation
    typedef enum logic [1:0]
    {
        grad_arith     = 2'h0,
        grad_move      = 2'h1,
        grad_move_from = 2'h2,
        grad_compare   = 2'h3
    } grad_kind_t;

    // control-move sequencer states
    typedef enum logic [2:0]
    {
        seq_idle  = 3'h1,
        seq_drain = 3'h2,
        seq_exec  = 3'h4
    } seq_state_t;

endpackage

// [logic/fp_move_sequencer.sv]
`timescale 1ns/1ns
module fp_move_sequencer
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic req_valid,
    input  wire logic pipeline_empty,
    output logic      busy,
    output logic      exec
);

    typedef struct packed
    {
        fpcs_pkg::seq_state_t state;
        logic                 busy;
        logic                 exec;
    } seq_t;

    seq_t cur;
    seq_t next_cur;

    always_comb
    begin
        next_cur      = cur;
        next_cur.exec = 1'b0;
        case (cur.state)
            fpcs_pkg::seq_idle:
            begin
                if (req_valid)
                begin
                    next_cur.state = fpcs_pkg::seq_drain;
                    next_cur.busy  = 1'b1;
                end
            end
            fpcs_pkg::seq_drain:
            begin
                if (pipeline_empty)
                begin
                    next_cur.state = fpcs_pkg::seq_exec;
                    next_cur.exec  = 1'b1;
                end
            end
            fpcs_pkg::seq_exec:
            begin
                next_cur.state = fpcs_pkg::seq_idle;
                next_cur.busy  = 1'b0;
            end
            default:
            begin
                next_cur.state = fpcs_pkg::seq_idle;
                next_cur.busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur <= '{state: fpcs_pkg::seq_idle, busy: 1'b0, exec: 1'b0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign busy = cur.busy;
    assign exec = cur.exec;

endmodule

// [logic/fp_unit_cause.sv]
`timescale 1ns/1ns
module fp_unit_cause
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       flush_denormal_bit,
    input  wire logic       unit_done,
    input  wire logic       unit_is_divide,
    input  wire logic [5:0] unit_raw_cause,
    input  wire logic       unit_denorm_result,
    input  wire logic       unit_denorm_input,
    output logic            cause_valid,
    output logic [5:0]      cause,
    output logic            result_to_zero,
    output logic            operand_to_zero
);

    typedef struct packed
    {
        logic       valid;
        logic [5:0] cause;
        logic       res_zero;
        logic       opnd_zero;
    } cg_t;

    cg_t cur;
    cg_t next_cur;

    always_comb
    begin
        next_cur       = cur;
        next_cur.valid = unit_done;
        if (unit_done)
        begin
            next_cur.cause = unit_raw_cause;
            // divide-by-zero only comes from the divider
            if (!unit_is_divide)
            begin
                next_cur.cause[fpcs_pkg::CAUSE_Z] = 1'b0;
            end
            // denormal result: trap, or flush to zero quietly
            if (unit_denorm_result && !flush_denormal_bit)
            begin
                next_cur.cause[fpcs_pkg::CAUSE_E] = 1'b1;
            end
            next_cur.res_zero = unit_denorm_result &&
                                flush_denormal_bit;
            // raw cause already reflects the zeroed operand, so any
            // zero-induced trap stays in place
            next_cur.opnd_zero = unit_denorm_input &&
                                 flush_denormal_bit;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur <= '{valid: 1'b0, cause: fpcs_pkg::CAUSE_NONE,
                     res_zero: 1'b0, opnd_zero: 1'b0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign cause_valid     = cur.valid;
    assign cause           = cur.cause;
    assign result_to_zero  = cur.res_zero;
    assign operand_to_zero = cur.opnd_zero;

endmodule

// [logic/fp_control_status_regs.sv]
`timescale 1ns/1ns
// Summary of operation
// - only control registers 0 and 31 exist; others read zero.
// - register 0 reads zero, implementation id, revision number.
// - status bits 22:18 always zero; all others readable and writable.
// - control moves wait for graduation drain and stall later decode.
// - flush clear traps denormal results; flush set zeroes them silently.
// - condition bits 31:25,23 updated by compares in graduation order.
// - six cause bits reflect last graduated or trapping instruction.
// - only queue instructions update status; moves limited to unimplemented.
// - unimplemented cause always traps.
// - enable bits 11:7 allow traps for matching IEEE causes.
// - untrapped arithmetic sets sticky flags 6:2; trapping leaves them.
// - rounding field 1:0 selects nearest, zero, plus, minus infinity.
// - rounding and enables change only by move write; broadcast.
// - enabled cause traps, discards result, leaves flags unchanged.
// - move write still updates status, then traps and aborts move.
// - move write to 31 loads every status bit except 22:18 after drain.
// - execution units deliver cause status on completion.
// - divide-by-zero cause only from divide unit.
// - software may directly set or clear cause and flag bits.
// - with flush set, denormal operands become zero, zero traps kept.
module fp_control_status_regs
#(
    // arbitrary identifier value, not tied to any product
    parameter logic [7:0] IMPL_ID  = 8'h5a,
    parameter logic [7:0] REVISION = 8'h01
)
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // control move request from decode
    input  wire logic        move_valid,
    input  wire logic        move_write,
    input  wire logic [4:0]  move_sel,
    input  wire logic [31:0] move_wdata,
    input  wire logic        pipeline_empty,
    output logic             decode_stall,
    output logic             move_done,
    output logic [31:0]      move_rdata,
    output logic             move_trap,
    // graduation of one instruction
    input  wire logic        grad_valid,
    input  wire logic        grad_from_fp_queue,
    input  wire logic [1:0]  grad_kind,
    input  wire logic [5:0]  grad_cause,
    input  wire logic        grad_cond_we,
    input  wire logic [2:0]  grad_cond_sel,
    input  wire logic        grad_cond_val,
    output logic             grad_trap,
    output logic             grad_discard,
    // execution unit completion
    input  wire logic        unit_done,
    input  wire logic        unit_is_divide,
    input  wire logic [5:0]  unit_raw_cause,
    input  wire logic        unit_denorm_result,
    input  wire logic        unit_denorm_input,
    output logic             unit_cause_valid,
    output logic [5:0]       unit_cause,
    output logic             unit_result_to_zero,
    output logic             unit_operand_to_zero,
    // broadcast to execution units
    output logic [1:0]       rounding_field,
    output logic [4:0]       trap_enables,
    output logic             flush_denormal_bit
);

    typedef struct packed
    {
        logic [31:0] status;
        logic        pend_write;
        logic [4:0]  pend_sel;
        logic [31:0] pend_wdata;
        logic        done;
        logic [31:0] rdata;
        logic        mtrap;
        logic        gtrap;
        logic        gdiscard;
        logic [1:0]  rm;
        logic [4:0]  en;
        logic        fs;
    } regs_t;

    regs_t cur;
    regs_t next_cur;

    logic  seq_busy;
    logic  seq_exec;

    // an unimplemented cause or any enabled IEEE cause forces a trap
    function automatic logic trap_check(input logic [5:0] c,
                                        input logic [4:0] en);
        trap_check = c[fpcs_pkg::CAUSE_E] |
                     (|(c[fpcs_pkg::IEEE_WIDTH-1:0] & en));
    endfunction

    function automatic logic [4:0] cond_pos(input logic [2:0] idx);
        if (idx == 3'h0)
        begin
            cond_pos = 5'(fpcs_pkg::COND_LO_BIT);
        end
        else
        begin
            cond_pos = 5'(fpcs_pkg::COND_HI_LSB - 1) + 5'(idx);
        end
    endfunction

    fp_move_sequencer u_seq
    (
        .core_clk       (core_clk),
        .sys_rst        (sys_rst),
        .req_valid      (move_valid && !seq_busy),
        .pipeline_empty (pipeline_empty),
        .busy           (seq_busy),
        .exec           (seq_exec)
    );

    fp_unit_cause u_cause
    (
        .core_clk           (core_clk),
        .sys_rst            (sys_rst),
        .flush_denormal_bit (cur.fs),
        .unit_done          (unit_done),
        .unit_is_divide     (unit_is_divide),
        .unit_raw_cause     (unit_raw_cause),
        .unit_denorm_result (unit_denorm_result),
        .unit_denorm_input  (unit_denorm_input),
        .cause_valid        (unit_cause_valid),
        .cause              (unit_cause),
        .result_to_zero     (unit_result_to_zero),
        .operand_to_zero    (unit_operand_to_zero)
    );

    always_comb
    begin
        logic [5:0]  gc;
        logic [31:0] ws;
        logic        gt;
        logic        upd;
        gc = fpcs_pkg::CAUSE_NONE;
        ws = '0;
        gt = 1'b0;
        upd = 1'b0;

        next_cur          = cur;
        next_cur.done     = 1'b0;
        next_cur.mtrap    = 1'b0;
        next_cur.gtrap    = 1'b0;
        next_cur.gdiscard = 1'b0;

        // capture the move while the sequencer is idle
        if (move_valid && !seq_busy)
        begin
            next_cur.pend_write = move_write;
            next_cur.pend_sel   = move_sel;
            next_cur.pend_wdata = move_wdata;
        end

        if (seq_exec)
        begin
            next_cur.done = 1'b1;
            if (cur.pend_write)
            begin
                if (cur.pend_sel == fpcs_pkg::CTL_STATUS)
                begin
                    ws = cur.pend_wdata & ~fpcs_pkg::UNIMPL_MASK;
                    next_cur.status = ws;
                    next_cur.rm = ws[fpcs_pkg::RM_LSB +: 2];
                    next_cur.en = ws[fpcs_pkg::ENABLE_LSB +:
                                     fpcs_pkg::IEEE_WIDTH];
                    next_cur.fs = ws[fpcs_pkg::FLUSH_BIT];
                    // status stays written even though the move traps
                    next_cur.mtrap = trap_check(
                        ws[fpcs_pkg::CAUSE_LSB +: fpcs_pkg::CAUSE_WIDTH],
                        ws[fpcs_pkg::ENABLE_LSB +:
                           fpcs_pkg::IEEE_WIDTH]);
                end
                // writes to register 0 or unknown numbers are dropped
            end
            else
            begin
                if (cur.pend_sel == fpcs_pkg::CTL_STATUS)
                begin
                    next_cur.rdata = cur.status;
                end
                else if (cur.pend_sel == fpcs_pkg::CTL_IMPL_REV)
                begin
                    next_cur.rdata = '0;
                    next_cur.rdata[fpcs_pkg::IMPL_LSB +:
                                   fpcs_pkg::ID_WIDTH] = IMPL_ID;
                    next_cur.rdata[fpcs_pkg::REV_LSB +:
                                   fpcs_pkg::ID_WIDTH] = REVISION;
                end
                else
                begin
                    next_cur.rdata = '0;
                end
            end
        end
        else if (grad_valid && grad_from_fp_queue)
        begin
            upd = 1'b1;
            case (fpcs_pkg::grad_kind_t'(grad_kind))
                fpcs_pkg::grad_move:
                begin
                    gc = grad_cause & fpcs_pkg::CAUSE_E_ONLY;
                end
                fpcs_pkg::grad_move_from:
                begin
                    upd = 1'b0;
                end
                default:
                begin
                    gc = grad_cause;
                end
            endcase
            if (upd)
            begin
                gt = trap_check(gc, cur.en);
                next_cur.gtrap    = gt;
                next_cur.gdiscard = gt;
                next_cur.status[fpcs_pkg::CAUSE_LSB +:
                                fpcs_pkg::CAUSE_WIDTH] = gc;
                if (!gt)
                begin
                    next_cur.status[fpcs_pkg::FLAG_LSB +:
                                    fpcs_pkg::IEEE_WIDTH] =
                        cur.status[fpcs_pkg::FLAG_LSB +:
                                   fpcs_pkg::IEEE_WIDTH] |
                        gc[fpcs_pkg::IEEE_WIDTH-1:0];
                    if (fpcs_pkg::grad_kind_t'(grad_kind) ==
                        fpcs_pkg::grad_compare && grad_cond_we)
                    begin
                        next_cur.status[cond_pos(grad_cond_sel)] =
                            grad_cond_val;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur <= '{status: fpcs_pkg::STATUS_RESET,
                     pend_write: 1'b0, pend_sel: fpcs_pkg::CTL_IMPL_REV,
                     pend_wdata: '0, done: 1'b0, rdata: '0,
                     mtrap: 1'b0, gtrap: 1'b0, gdiscard: 1'b0,
                     rm: 2'h0, en: 5'h00, fs: 1'b0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign decode_stall       = seq_busy;
    assign move_done          = cur.done;
    assign move_rdata         = cur.rdata;
    assign move_trap          = cur.mtrap;
    assign grad_trap          = cur.gtrap;
    assign grad_discard       = cur.gdiscard;
    assign rounding_field     = cur.rm;
    assign trap_enables       = cur.en;
    assign flush_denormal_bit = cur.fs;

endmodule

// [verification/fpcs_properties.sv]
`timescale 1ns/1ns
module fpcs_properties
(
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       move_valid,
    input wire logic       pipeline_empty,
    input wire logic       decode_stall,
    input wire logic       move_done,
    input wire logic       move_trap,
    input wire logic       grad_valid,
    input wire logic       grad_from_fp_queue,
    input wire logic [1:0] grad_kind,
    input wire logic [5:0] grad_cause,
    input wire logic       grad_trap,
    input wire logic       grad_discard,
    input wire logic       unit_done,
    input wire logic       unit_is_divide,
    input wire logic       unit_denorm_result,
    input wire logic [5:0] unit_raw_cause,
    input wire logic       unit_cause_valid,
    input wire logic [5:0] unit_cause,
    input wire logic       unit_result_to_zero,
    input wire logic [1:0] rounding_field,
    input wire logic [4:0] trap_enables,
    input wire logic       flush_denormal_bit
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // move-from never traps; move kind traps on the unimplemented cause only
    logic grad_hit;
    assign grad_hit = (grad_cause[5] && grad_kind != 2'h2)
        || ((grad_kind == 2'h0 || grad_kind == 2'h3)
        && (grad_cause[4:0] & trap_enables) != 5'h00);

    sequence s_accept;
        move_valid && !decode_stall;
    endsequence
    sequence s_grad;
        grad_valid && grad_from_fp_queue && !decode_stall;
    endsequence

    a_stall_window: assert property (s_accept |=> decode_stall [*2])
        else $error("decode not stalled after move accepted");
    a_move_latency: assert property (s_accept ##1 pipeline_empty
        |-> ##2 move_done)
        else $error("move not completed two cycles after drain");
    a_done_release: assert property ($fell(decode_stall)
        |-> move_done)
        else $error("stall released without move completion");
    a_done_pulse: assert property (move_done |=> !move_done)
        else $error("move done longer than one cycle");
    a_move_trap: assert property (move_trap |-> move_done)
        else $error("move trap outside move completion");
    a_trap_taken: assert property (s_grad ##0 grad_hit
        |=> grad_trap && grad_discard)
        else $error("enabled cause did not trap");
    a_trap_masked: assert property (s_grad ##0 !grad_hit
        |=> !grad_trap)
        else $error("trap without enabled cause");
    a_queue_only: assert property (grad_valid && !grad_from_fp_queue
        |=> !grad_trap)
        else $error("non queue instruction trapped");
    a_settings_hold: assert property (!move_done |-> $stable(rounding_field)
        && $stable(trap_enables) && $stable(flush_denormal_bit))
        else $error("broadcast settings changed without move");
    a_divide_only: assert property (unit_done && !unit_is_divide
        |=> unit_cause_valid && !unit_cause[3])
        else $error("divide by zero cause from non divide unit");
    a_denorm_trap: assert property (unit_done && unit_denorm_result
        && !flush_denormal_bit |=> unit_cause[5])
        else $error("denormal result did not flag unimplemented");
    a_denorm_zero: assert property (unit_done && unit_denorm_result
        && flush_denormal_bit && !unit_raw_cause[5]
        |=> unit_result_to_zero && !unit_cause[5])
        else $error("flushed denormal result not zeroed quietly");
endmodule

bind fp_control_status_regs fpcs_properties chk (.*);

// [verification/fp_pipe_model.sv]
`timescale 1ns/1ns
module fp_pipe_model
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       decode_stall,
    input  wire logic [1:0] lag,
    output logic            pipeline_empty
);
    logic [1:0] waited;

    // earlier instructions keep graduating for lag cycles after the stall
    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            waited <= 2'h0;
        else if (!decode_stall)
            waited <= 2'h0;
        else if (waited != lag)
            waited <= waited + 2'h1;

    assign pipeline_empty = decode_stall && waited == lag;
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ns
module testbench;
    // arbitrary identifier values
    localparam logic [7:0] ID_VAL  = 8'h3c;
    localparam logic [7:0] REV_VAL = 8'h07;
    logic        core_clk, sys_rst, move_valid, move_write, pipeline_empty;
    logic        decode_stall, move_done, move_trap, grad_valid, grad_trap;
    logic        grad_from_fp_queue, grad_cond_we, grad_cond_val, grad_discard;
    logic        unit_done, unit_is_divide, unit_denorm_result;
    logic        unit_denorm_input, unit_cause_valid, unit_result_to_zero;
    logic        unit_operand_to_zero, flush_denormal_bit;
    logic [4:0]  move_sel, trap_enables;
    logic [31:0] move_wdata, move_rdata, m_st;
    logic [1:0]  grad_kind, rounding_field, lag;
    logic [5:0]  grad_cause, unit_raw_cause, unit_cause;
    logic [2:0]  grad_cond_sel;
    int          failures, num_checks;

    fp_control_status_regs #(.IMPL_ID(ID_VAL), .REVISION(REV_VAL)) uut (.*);
    fp_pipe_model pipe (.*);

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic mv(input logic wr, input logic [4:0] sel,
                      input logic [31:0] d);
        int          n;
        int          l;
        logic [31:0] er;
        logic        et;
        l = $urandom % 4;
        er = 32'h0;
        et = 1'b0;
        @(posedge core_clk);
        move_valid <= 1'b1;
        move_write <= wr;
        move_sel <= sel;
        move_wdata <= d;
        lag <= 2'(l);
        @(posedge core_clk);
        move_valid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while (move_done !== 1'b1 && n < 40);
        if (wr && sel == fpcs_pkg::CTL_STATUS)
        begin
            m_st = d & ~fpcs_pkg::UNIMPL_MASK;
            et = m_st[17] || (m_st[16:12] & m_st[11:7]) != 5'h00;
        end
        if (sel == fpcs_pkg::CTL_IMPL_REV)
            er = {16'h0000, ID_VAL, REV_VAL};
        if (sel == fpcs_pkg::CTL_STATUS)
            er = m_st;
        chk(n == 2 + l, "move latency");
        chk(move_trap === et, "move trap");
        chk(wr || move_rdata === er, "read data");
        chk(rounding_field === m_st[1:0], "rounding field");
        chk(trap_enables === m_st[11:7], "enables");
        chk(flush_denormal_bit === m_st[24], "flush bit");
    endtask

    task automatic grad(input logic [1:0] k, input logic [5:0] c,
                        input logic q);
        logic [5:0] e;
        logic       t;
        int         s;
        s = $urandom % 8;
        @(posedge core_clk);
        grad_valid <= 1'b1;
        grad_from_fp_queue <= q;
        grad_kind <= k;
        grad_cause <= c;
        grad_cond_we <= (k == 2'h3);
        grad_cond_sel <= 3'(s);
        grad_cond_val <= c[0];
        @(posedge core_clk);
        grad_valid <= 1'b0;
        #1;
        e = (k == 2'h1) ? (c & fpcs_pkg::CAUSE_E_ONLY) : c;
        t = q && k != 2'h2 && (e[5] || (e[4:0] & m_st[11:7]) != 5'h00);
        chk(grad_trap === t && grad_discard === t, "graduation trap");
        if (q && k != 2'h2)
        begin
            m_st[17:12] = e;
            if (!t)
                m_st[6:2] = m_st[6:2] | e[4:0];
            if (!t && k == 2'h3)
                m_st[s == 0 ? 23 : 24 + s] = c[0];
        end
    endtask

    task automatic unit(input logic dv, input logic dr, input logic di_req,
                        input logic [5:0] rc);
        logic [5:0] ec;
        logic       fl;
        logic       di;
        fl = m_st[24];
        di = fl && di_req;
        @(posedge core_clk);
        unit_done <= 1'b1;
        unit_is_divide <= dv;
        unit_raw_cause <= rc;
        unit_denorm_result <= dr;
        unit_denorm_input <= di_req;
        @(posedge core_clk);
        unit_done <= 1'b0;
        #1;
        ec = rc;
        ec[3] = rc[3] && dv;
        ec[5] = dr && !fl;
        if (di)
            ec = ec & 6'h20;
        chk(unit_cause_valid === 1'b1, "unit valid");
        chk((unit_cause & (di ? 6'h20 : 6'h3f)) === ec, "unit cause");
        chk(unit_result_to_zero === (dr && fl), "result flush");
        chk(unit_operand_to_zero === di, "operand flush");
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        test_done();
    end

    initial
    begin
        {move_valid, move_write, grad_valid, grad_from_fp_queue} = 4'h0;
        {grad_cond_we, grad_cond_val, unit_done, unit_is_divide} = 4'h0;
        {unit_denorm_result, unit_denorm_input} = 2'h0;
        {move_sel, move_wdata, grad_kind, grad_cause} = '0;
        {grad_cond_sel, unit_raw_cause, lag} = '0;
        failures = 0;
        num_checks = 0;
        m_st = 32'h0;
        void'($urandom(6702));
        sys_rst = 1'b1;
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk(decode_stall === 1'b0 && grad_trap === 1'b0, "reset state");
        mv(1'b0, 5'h1f, 32'h0);
        mv(1'b0, 5'h00, 32'h0);
        mv(1'b1, 5'h00, 32'hffffffff);
        mv(1'b0, 5'h00, 32'h0);
        mv(1'b1, 5'h07, 32'hffffffff);
        mv(1'b0, 5'h05, 32'h0);
        mv(1'b0, 5'h1f, 32'h0);
        for (int r = 0; r < 4; r++)
            mv(1'b1, 5'h1f, ($urandom & 32'hfffc0ffc) | r);
        mv(1'b1, 5'h1f, 32'h00020000);
        mv(1'b1, 5'h1f, 32'h00010800);
        mv(1'b0, 5'h1f, 32'h0);
        for (int i = 0; i < 60; i++)
        begin
            if (i % 8 == 0)
                mv(1'b1, 5'h1f, $urandom);
            grad(2'($urandom), 6'($urandom), $urandom % 4 != 0);
            unit($urandom, $urandom, $urandom, 6'($urandom) & 6'h1f);
            mv(1'b0, 5'h1f, 32'h0);
        end
        @(posedge core_clk);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        m_st = 32'h0;
        mv(1'b0, 5'h1f, 32'h0);
        test_done();
    end
endmodule
